/* hw/bsm_pkg.sv */
// constants and types shared by the bit-serial i/o bus master
package bsm_pkg;

    // address field positions
    localparam int BSM_ADDR_W = 12;
    localparam int BSM_BASE_LSB = 1;
    localparam int BSM_BASE_MSB = 12;
    localparam int BSM_DISP_W = 8;
    localparam int BSM_WORD_W = 16;
    localparam int BSM_BYTE_W = 8;
    localparam logic [2:0] BSM_ADDR_TOP_ZERO = 3'h0;

    // transfer length encoding: a count field of zero stands for sixteen bits
    localparam logic [3:0] BSM_COUNT_FULL_CODE = 4'h0;
    localparam logic [3:0] BSM_COUNT_NARROW_MAX = 4'h8;
    localparam logic [4:0] BSM_LAST_IDX_FULL = 5'h0F;

    // bus timing, counted in phases; one phase is one system clock
    localparam int BSM_PHASES_PER_CYCLE = 4;
    localparam int BSM_ADDR_HOLD_PHASES = 8;
    localparam int BSM_STROBE_PHASES = 2;
    localparam logic [2:0] BSM_SLOT_LAST = 3'(BSM_ADDR_HOLD_PHASES - 1);
    localparam logic [2:0] BSM_STROBE_FIRST = 3'(BSM_PHASES_PER_CYCLE);
    localparam logic [2:0] BSM_STROBE_LAST = 3'(BSM_PHASES_PER_CYCLE + BSM_STROBE_PHASES - 1);
    localparam logic [2:0] BSM_SAMPLE_SLOT = 3'h6;

    // clock phases of the four-phase system clock
    typedef enum logic [3:0] {
        BSM_PH1 = 4'h1,
        BSM_PH2 = 4'h2,
        BSM_PH3 = 4'h4,
        BSM_PH4 = 4'h8
    } bsm_phase_e;

    // operations accepted on the command port
    typedef enum logic [2:0] {
        BSM_OP_LOAD = 3'h0,
        BSM_OP_STORE = 3'h1,
        BSM_OP_SET_ONE = 3'h2,
        BSM_OP_SET_ZERO = 3'h3,
        BSM_OP_TEST = 3'h4
    } bsm_op_e;

endpackage : bsm_pkg

/* hw/bsm_phase_if.sv */
// carrier for the four-phase clock position between phase generator and master
`timescale 1ns/1ps
interface bsm_phase_if;
    import bsm_pkg::*;
    bsm_phase_e phase;

    modport gen (output phase);
    modport user (input phase);
endinterface : bsm_phase_if

/* hw/bsm_phase_gen.sv */
// four-phase clock position generator, one phase per system clock
`timescale 1ns/1ps
module bsm_phase_gen (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // phase position
    bsm_phase_if.gen ph
);
    import bsm_pkg::*;

    typedef struct packed {
        bsm_phase_e phase;
    } bsm_phase_s;

    bsm_phase_s cur;
    bsm_phase_s next_cur;

    always_comb begin
        next_cur = cur;
        unique case (cur.phase)
            BSM_PH1: next_cur.phase = BSM_PH2;
            BSM_PH2: next_cur.phase = BSM_PH3;
            BSM_PH3: next_cur.phase = BSM_PH4;
            BSM_PH4: next_cur.phase = BSM_PH1;
            default: next_cur.phase = BSM_PH1;
        endcase
    end

    // reset parks at phase 4 so the first clock after release is phase 1
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            cur.phase <= BSM_PH4;
        end else begin
            cur <= next_cur;
        end
    end

    assign ph.phase = cur.phase;

endmodule : bsm_phase_gen

/* hw/bsm_master.sv */
// bit-serial i/o bus master: bit addressing, output strobe, input sampling
`timescale 1ns/1ps
module bsm_master (
    // clock and reset
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    // command port
    input wire logic i_cmd_valid,
    output logic o_cmd_ready,
    input wire bsm_pkg::bsm_op_e i_cmd_op,
    input wire logic [15:0] i_base_address_workspace_register,
    input wire logic [7:0] i_disp,
    input wire logic [3:0] i_count,
    input wire logic [15:0] i_mem_word,
    // results
    output logic o_done,
    output logic o_mem_wr,
    output logic [15:0] o_mem_word,
    output logic o_match_valid,
    output logic o_match_status_flag,
    // serial i/o bus
    output logic [0:14] o_addr,
    output logic o_addr_valid,
    output logic o_serial_out_line,
    output logic o_serial_out_strobe,
    input wire logic i_serial_in_line
);
    import bsm_pkg::*;

    typedef enum logic [2:0] {
        BSM_ST_IDLE = 3'h1,
        BSM_ST_XFER = 3'h2,
        BSM_ST_FINISH = 3'h4
    } bsm_state_e;

    typedef struct packed {
        // sequencing
        bsm_state_e state;
        bsm_op_e op;
        logic [BSM_ADDR_W-1:0] bit_addr;
        logic [2:0] slot;
        logic [4:0] bit_idx;
        logic [4:0] last_idx;
        // bit pattern in flight
        logic [BSM_WORD_W-1:0] shift;
        logic [BSM_WORD_W-1:0] acc;
        logic [BSM_BYTE_W-1:0] keep_low;
        logic narrow;
        // bus lines
        logic addr_valid;
        logic out_line;
        logic strobe;
        // results
        logic done;
        logic mem_wr;
        logic [BSM_WORD_W-1:0] mem_word;
        logic match_valid;
        logic match;
        // input pin synchroniser
        logic in_meta;
        logic in_sync;
    } bsm_core_s;

    bsm_core_s cur;
    bsm_core_s next_cur;

    // shared phase position; commands wait for phase 1 so every bit stays aligned
    bsm_phase_if u_ph_if ();

    bsm_phase_gen u_phase (
        .i_clk_sys(i_clk_sys),
        .i_resetn(i_resetn),
        .ph(u_ph_if.gen)
    );

    // operations that drive the output line and strobe
    function automatic logic is_output_op(input bsm_op_e op);
        return (op == BSM_OP_LOAD) || (op == BSM_OP_SET_ONE) || (op == BSM_OP_SET_ZERO);
    endfunction : is_output_op

    // operations that sample the input line
    function automatic logic is_input_op(input bsm_op_e op);
        return (op == BSM_OP_STORE) || (op == BSM_OP_TEST);
    endfunction : is_input_op

    // single-bit operations carry a displacement and move exactly one bit
    function automatic logic is_single_op(input bsm_op_e op);
        return (op == BSM_OP_SET_ONE) || (op == BSM_OP_SET_ZERO) || (op == BSM_OP_TEST);
    endfunction : is_single_op

    // first bit address of an operation
    function automatic logic [BSM_ADDR_W-1:0] first_addr(
        input bsm_op_e op,
        input logic [15:0] base_reg,
        input logic [7:0] disp
    );
        logic [BSM_ADDR_W-1:0] base;
        logic [BSM_ADDR_W-1:0] ext;
        base = base_reg[BSM_BASE_MSB:BSM_BASE_LSB];
        ext = {{(BSM_ADDR_W-BSM_DISP_W){disp[BSM_DISP_W-1]}}, disp};
        // the sum wraps at the top of the 4096-bit space
        if (is_single_op(op)) begin
            return BSM_ADDR_W'(base + ext);
        end else begin
            return base;
        end
    endfunction : first_addr

    // a transfer whose count is 1 to 8 works on the left byte only
    function automatic logic count_is_narrow(input logic [3:0] cnt);
        return (cnt != BSM_COUNT_FULL_CODE) && (cnt <= BSM_COUNT_NARROW_MAX);
    endfunction : count_is_narrow

    // output ops raise the strobe on the second phase 2 of each bit, for two phases
    function automatic logic strobe_due(input bsm_op_e op, input logic [2:0] slot);
        return is_output_op(op)
            && (slot >= 3'(BSM_STROBE_FIRST - 3'h1))
            && (slot < BSM_STROBE_LAST);
    endfunction : strobe_due

    // input ops take one sample per bit, at the phase 4 to phase 1 edge
    function automatic logic sample_due(input bsm_op_e op, input logic [2:0] slot);
        return is_input_op(op) && (slot == BSM_SAMPLE_SLOT);
    endfunction : sample_due

    // short counts fill the left byte and hand the right byte back untouched
    function automatic logic [BSM_WORD_W-1:0] stored_word(
        input logic [BSM_WORD_W-1:0] acc,
        input logic [BSM_BYTE_W-1:0] keep_low,
        input logic narrow
    );
        if (narrow) begin
            return {acc[BSM_BYTE_W-1:0], keep_low};
        end else begin
            return acc;
        end
    endfunction : stored_word

    always_comb begin
        next_cur = cur;
        // two-stage synchroniser on the input pin
        next_cur.in_meta = i_serial_in_line;
        next_cur.in_sync = cur.in_meta;
        next_cur.done = 1'b0;
        next_cur.mem_wr = 1'b0;
        next_cur.match_valid = 1'b0;
        unique case (cur.state)
            BSM_ST_IDLE: begin
                next_cur.strobe = 1'b0;
                if (i_cmd_valid && o_cmd_ready) begin
                    next_cur.state = BSM_ST_XFER;
                    next_cur.op = i_cmd_op;
                    next_cur.bit_addr = first_addr(i_cmd_op, i_base_address_workspace_register,
                                                   i_disp);
                    next_cur.slot = 3'h0;
                    next_cur.bit_idx = 5'h00;
                    next_cur.acc = '0;
                    next_cur.keep_low = i_mem_word[BSM_BYTE_W-1:0];
                    next_cur.narrow = count_is_narrow(i_count);
                    if (is_single_op(i_cmd_op)) begin
                        next_cur.last_idx = 5'h00;
                    end else if (i_count == BSM_COUNT_FULL_CODE) begin
                        next_cur.last_idx = BSM_LAST_IDX_FULL;
                    end else begin
                        next_cur.last_idx = 5'({1'b0, i_count} - 5'h01);
                    end
                    // the left byte is shifted down so bit 8 leaves first
                    if (count_is_narrow(i_count)) begin
                        next_cur.shift = {8'h00, i_mem_word[BSM_WORD_W-1:BSM_BYTE_W]};
                    end else begin
                        next_cur.shift = i_mem_word;
                    end
                    // the address appears at the next edge, which opens phase 2
                    next_cur.addr_valid = 1'b1;
                    unique case (i_cmd_op)
                        BSM_OP_LOAD: begin
                            if (count_is_narrow(i_count)) begin
                                next_cur.out_line = i_mem_word[BSM_BYTE_W];
                            end else begin
                                next_cur.out_line = i_mem_word[0];
                            end
                        end
                        BSM_OP_SET_ONE: next_cur.out_line = 1'b1;
                        BSM_OP_SET_ZERO: next_cur.out_line = 1'b0;
                        default: next_cur.out_line = 1'b0;
                    endcase
                end else begin
                    // idle lines rest low so no peripheral sees a stray address
                    next_cur.addr_valid = 1'b0;
                    next_cur.out_line = 1'b0;
                    next_cur.slot = 3'h0;
                end
            end
            BSM_ST_XFER: begin
                // one slot is one phase; eight slots carry one bit
                next_cur.slot = 3'(cur.slot + 3'h1);
                // registered, so high during slots strobe_first..strobe_last
                next_cur.strobe = strobe_due(cur.op, cur.slot);
                // sampling at the end of the second phase 4 leaves room for the
                // synchroniser delay behind the peripheral's settled level
                if (sample_due(cur.op, cur.slot)) begin
                    next_cur.acc[cur.bit_idx[3:0]] = cur.in_sync;
                end
                if (cur.slot == BSM_SLOT_LAST) begin
                    // dropping the address marks the end of the transfer for the far side
                    if (cur.bit_idx == cur.last_idx) begin
                        next_cur.state = BSM_ST_FINISH;
                        next_cur.addr_valid = 1'b0;
                        next_cur.out_line = 1'b0;
                    end else begin
                        next_cur.bit_idx = 5'(cur.bit_idx + 5'h01);
                        next_cur.bit_addr = BSM_ADDR_W'(cur.bit_addr + 12'h001);
                        next_cur.shift = {1'b0, cur.shift[BSM_WORD_W-1:1]};
                        if (cur.op == BSM_OP_LOAD) begin
                            next_cur.out_line = cur.shift[1];
                        end
                    end
                end
            end
            BSM_ST_FINISH: begin
                next_cur.state = BSM_ST_IDLE;
                next_cur.strobe = 1'b0;
                next_cur.done = 1'b1;
                if (cur.op == BSM_OP_STORE) begin
                    next_cur.mem_wr = 1'b1;
                    next_cur.mem_word = stored_word(cur.acc, cur.keep_low, cur.narrow);
                end
                if (cur.op == BSM_OP_TEST) begin
                    next_cur.match_valid = 1'b1;
                    next_cur.match = cur.acc[0];
                end
            end
            default: begin
                next_cur.state = BSM_ST_IDLE;
                next_cur.addr_valid = 1'b0;
                next_cur.strobe = 1'b0;
                next_cur.out_line = 1'b0;
            end
        endcase
    end

    // every field has a constant reset so the bus lines are defined from the first cycle
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            cur.state <= BSM_ST_IDLE;
            cur.op <= BSM_OP_LOAD;
            cur.bit_addr <= '0;
            cur.slot <= 3'h0;
            cur.bit_idx <= 5'h00;
            cur.last_idx <= 5'h00;
            cur.shift <= '0;
            cur.acc <= '0;
            cur.keep_low <= '0;
            cur.narrow <= 1'b0;
            cur.addr_valid <= 1'b0;
            cur.out_line <= 1'b0;
            cur.strobe <= 1'b0;
            cur.done <= 1'b0;
            cur.mem_wr <= 1'b0;
            cur.mem_word <= '0;
            cur.match_valid <= 1'b0;
            cur.match <= 1'b0;
            cur.in_meta <= 1'b0;
            cur.in_sync <= 1'b0;
        end else begin
            cur <= next_cur;
        end
    end

    // commands start only at phase 1 so every address opens on phase 2
    assign o_cmd_ready = (cur.state == BSM_ST_IDLE) && (u_ph_if.phase == BSM_PH1);

    // top three address lines are never driven high by this bus
    assign o_addr = {BSM_ADDR_TOP_ZERO, cur.bit_addr};
    assign o_addr_valid = cur.addr_valid;
    assign o_serial_out_line = cur.out_line;
    assign o_serial_out_strobe = cur.strobe;
    assign o_done = cur.done;
    assign o_mem_wr = cur.mem_wr;
    assign o_mem_word = cur.mem_word;
    assign o_match_valid = cur.match_valid;
    assign o_match_status_flag = cur.match;

endmodule : bsm_master

/* tb/bsm_master_chk.sv */
// port assertions for the bit-serial bus master
`timescale 1ns/1ps
module bsm_chk (
    // clock and command
    input wire logic i_clk_sys,
    input wire logic i_resetn,
    input wire logic i_cmd_valid,
    input wire logic o_cmd_ready,
    input wire bsm_pkg::bsm_op_e i_cmd_op,
    input wire logic [15:0] i_base_address_workspace_register,
    input wire logic [7:0] i_disp,
    input wire logic [3:0] i_count,
    // results and bus
    input wire logic o_done,
    input wire logic o_mem_wr,
    input wire logic o_match_valid,
    input wire logic o_match_status_flag,
    input wire logic [0:14] o_addr,
    input wire logic o_addr_valid,
    input wire logic o_serial_out_line,
    input wire logic o_serial_out_strobe
);
    import bsm_pkg::*;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_resetn);
    logic take;
    logic is_out;
    logic [11:0] addr_now;
    logic [11:0] first;
    logic [7:0] cyc;
    logic [7:0] cyc_exp;
    bsm_op_e op_q;
    assign take = i_cmd_valid && o_cmd_ready;
    assign addr_now = o_addr[3:14];
    assign is_out = op_q != BSM_OP_STORE && op_q != BSM_OP_TEST;
    assign first = i_base_address_workspace_register[12:1]
        + ((i_cmd_op > BSM_OP_STORE) ? {{4{i_disp[7]}}, i_disp} : 12'h000);
    // cycles since the take, so the answer time can be tied to the bit count
    always_ff @(posedge i_clk_sys) begin
        if (!i_resetn) begin
            op_q <= BSM_OP_LOAD;
            cyc <= 8'h00;
            cyc_exp <= 8'h00;
        end else if (take) begin
            op_q <= i_cmd_op;
            cyc <= 8'h01;
            cyc_exp <= (i_cmd_op > BSM_OP_STORE) ? 8'h0A : {i_count == 4'h0, i_count, 3'h2};
        end else begin
            cyc <= cyc + 8'h01;
        end
    end
    sequence s_bit_start;
        o_addr_valid && (!$past(o_addr_valid) || addr_now != $past(addr_now));
    endsequence
    sequence s_strobe;
        !o_serial_out_strobe [*4] ##1 o_serial_out_strobe [*2] ##1 !o_serial_out_strobe;
    endsequence
    property p_addr_zero;
        o_addr_valid |-> o_addr[0:2] == BSM_ADDR_TOP_ZERO;
    endproperty
    property p_first_addr;
        take |=> o_addr_valid && addr_now == $past(first);
    endproperty
    property p_addr_hold;
        s_bit_start |=> (o_addr_valid && $stable(o_addr) && $stable(o_serial_out_line)) [*7];
    endproperty
    property p_strobe_out;
        s_bit_start ##0 is_out |-> s_strobe;
    endproperty
    property p_incr;
        o_addr_valid && $past(o_addr_valid) && addr_now != $past(addr_now)
            |-> addr_now == 12'($past(addr_now) + 12'h001);
    endproperty
    property p_done_time;
        o_done |-> cyc == cyc_exp;
    endproperty
    property p_set_val;
        o_serial_out_strobe && op_q inside {BSM_OP_SET_ONE, BSM_OP_SET_ZERO}
            |-> o_serial_out_line == (op_q == BSM_OP_SET_ONE);
    endproperty
    property p_result_kind;
        (o_done || o_mem_wr || o_match_valid) |-> o_done && o_mem_wr == (op_q == BSM_OP_STORE)
            && o_match_valid == (op_q == BSM_OP_TEST);
    endproperty
    property p_flag_hold;
        !o_match_valid |-> $stable(o_match_status_flag);
    endproperty
    a_addr_zero: assert property (p_addr_zero) else $error("upper lines not zero");
    a_first_addr: assert property (p_first_addr) else $error("wrong first address");
    a_addr_hold: assert property (p_addr_hold) else $error("address not held");
    a_strobe_out: assert property (p_strobe_out) else $error("strobe misplaced");
    a_incr: assert property (p_incr) else $error("address step not one");
    a_done_time: assert property (p_done_time) else $error("answer late or early");
    a_set_val: assert property (p_set_val) else $error("set value wrong");
    a_result_kind: assert property (p_result_kind) else $error("result pulse wrong");
    a_flag_hold: assert property (p_flag_hold) else $error("flag moved");
endmodule : bsm_chk

bind bsm_master bsm_chk u_chk (
    .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_cmd_valid(i_cmd_valid),
    .o_cmd_ready(o_cmd_ready), .i_cmd_op(i_cmd_op), .i_disp(i_disp), .i_count(i_count),
    .i_base_address_workspace_register(i_base_address_workspace_register),
    .o_done(o_done), .o_mem_wr(o_mem_wr), .o_match_valid(o_match_valid),
    .o_match_status_flag(o_match_status_flag), .o_addr(o_addr), .o_addr_valid(o_addr_valid),
    .o_serial_out_line(o_serial_out_line), .o_serial_out_strobe(o_serial_out_strobe)
);

/* tb/bsm_peer.sv */
// addressed peripherals: one latch per bit address
`timescale 1ns/1ps
module bsm_peer (
    // clock
    input wire logic i_clk_sys,
    // bus from the master
    input wire logic [0:14] i_addr,
    input wire logic i_addr_valid,
    input wire logic i_serial_out_line,
    input wire logic i_serial_out_strobe,
    // bench control
    input wire logic i_slow,
    // returned bit
    output logic o_serial_in_line
);
    logic [4095:0] mem;
    logic [11:0] last_addr = 12'h000;
    logic [1:0] age = 2'h0;
    logic junk = 1'b0;
    logic fresh;
    assign fresh = i_addr[3:14] != last_addr;
    // unaddressed line alternates so a badly timed sample cannot pass by luck
    assign o_serial_in_line = (i_addr_valid && !(i_slow && (fresh || age == 2'h0)))
        ? mem[i_addr[3:14]] : junk;
    always @(posedge i_clk_sys) begin
        junk <= ~junk;
        last_addr <= i_addr[3:14];
        age <= fresh ? 2'h0 : ((age == 2'h3) ? age : age + 2'h1);
        if (i_serial_out_strobe && i_addr_valid) begin
            mem[i_addr[3:14]] <= i_serial_out_line;
        end
    end
endmodule : bsm_peer

/* tb/tb_bit_serial_io_bus_master.sv */
// self-checking bench for the bit-serial bus master
`timescale 1ns/1ps
module tb_bit_serial_io_bus_master;
    import bsm_pkg::*;
    typedef struct {
        bsm_op_e op;
        logic [11:0] addr;
        int n;
        logic [15:0] word;
    } bsm_note_s;
    logic i_clk_sys = 1'b0;
    logic i_resetn = 1'b0;
    logic cmd_valid = 1'b0;
    bsm_op_e cmd_op = BSM_OP_LOAD;
    logic [15:0] base_reg = 16'h0000;
    logic [7:0] disp = 8'h00;
    logic [3:0] count = 4'h0;
    logic [15:0] mem_word = 16'h0000;
    logic slow = 1'b0;
    logic cmd_ready, done, mem_wr, match_valid, match_flag, addr_valid, out_line, strobe, in_line, eb;
    logic [15:0] mem_out;
    logic [0:14] addr;
    logic [11:0] hw;
    logic [7:0] d;
    int seed = 81;
    int bad_count = 0;
    int comparisons = 0;
    int i;
    int j;
    bsm_note_s got;
    bsm_note_s notes[$];

    always #10 i_clk_sys = ~i_clk_sys;

    bsm_master uut (
        .i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_cmd_valid(cmd_valid),
        .o_cmd_ready(cmd_ready), .i_cmd_op(cmd_op), .i_disp(disp), .i_count(count),
        .i_base_address_workspace_register(base_reg), .i_mem_word(mem_word),
        .o_done(done), .o_mem_wr(mem_wr), .o_mem_word(mem_out), .o_match_valid(match_valid),
        .o_match_status_flag(match_flag), .o_addr(addr), .o_addr_valid(addr_valid),
        .o_serial_out_line(out_line), .o_serial_out_strobe(strobe), .i_serial_in_line(in_line)
    );
    bsm_peer peer (
        .i_clk_sys(i_clk_sys), .i_addr(addr), .i_addr_valid(addr_valid),
        .i_serial_out_line(out_line), .i_serial_out_strobe(strobe), .i_slow(slow),
        .o_serial_in_line(in_line)
    );

    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : give_verdict

    // notes the expected answer, holds the request until taken, waits for the answer
    task automatic issue(input bsm_op_e op, input logic [3:0] c, input logic [15:0] w);
        bsm_note_s e;
        int k;
        logic [31:0] r;
        r = $random(seed);
        e.op = op;
        e.n = (op > BSM_OP_STORE) ? 1 : ((c == 4'h0) ? 16 : int'(c));
        e.addr = hw + ((op > BSM_OP_STORE) ? {{4{d[7]}}, d} : 12'h000);
        e.word = (op == BSM_OP_LOAD) ? w : (e.n <= 8) ? {8'h00, w[7:0]} : 16'h0000;
        for (k = 0; k < e.n && op == BSM_OP_STORE; k++) begin
            e.word[(e.n <= 8) ? 8 + k : k] = peer.mem[12'(e.addr + k)];
        end
        if (op == BSM_OP_TEST) begin
            e.word = 16'(peer.mem[e.addr]);
        end
        notes.push_back(e);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        base_reg <= {r[2:0], hw, r[3]};
        disp <= d;
        count <= c;
        mem_word <= w;
        do begin
            @(posedge i_clk_sys);
        end while (cmd_ready !== 1'b1);
        cmd_valid <= 1'b0;
        for (k = 0; k < 300 && notes.size() > 0; k++) begin
            @(posedge i_clk_sys);
        end
        check("answer count", 16'(notes.size()), 16'h0000);
    endtask : issue

    always @(posedge i_clk_sys) begin
        if (done === 1'b1 && notes.size() > 0) begin
            got = notes.pop_front();
            check("store pulse", 16'(mem_wr), 16'(got.op == BSM_OP_STORE));
            check("test pulse", 16'(match_valid), 16'(got.op == BSM_OP_TEST));
            if (got.op == BSM_OP_STORE) begin
                check("stored word", mem_out, got.word);
            end
            if (got.op == BSM_OP_TEST) begin
                check("equal flag", 16'(match_flag), got.word);
            end
            for (j = 0; j < got.n && is_wr(got.op); j++) begin
                eb = (got.op == BSM_OP_LOAD) ? got.word[(got.n <= 8) ? 8 + j : j]
                    : (got.op == BSM_OP_SET_ONE);
                check("peer bit", 16'(peer.mem[12'(got.addr + j)]), 16'(eb));
            end
        end
    end

    function automatic logic is_wr(input bsm_op_e op);
        return op != BSM_OP_STORE && op != BSM_OP_TEST;
    endfunction : is_wr

    initial begin
        for (i = 0; i < 4096; i++) begin
            peer.mem[i] = 1'($random(seed));
        end
        repeat (12) @(posedge i_clk_sys);
        i_resetn <= 1'b1;
        @(posedge i_clk_sys);
        // every count code: load a word, then read the same bits back
        for (i = 0; i < 16; i++) begin
            hw = 12'($random(seed));
            d = 8'($random(seed));
            slow <= 1'(i % 2);
            issue(BSM_OP_LOAD, 4'(i), 16'($random(seed)));
            issue(BSM_OP_STORE, 4'(i), 16'($random(seed)));
        end
        // displacement extremes with the address wrapping at both ends
        for (i = 0; i < 8; i++) begin
            hw = (i % 2 == 0) ? 12'h005 : 12'hFFA;
            d = (i < 2) ? 8'h80 : (i < 4) ? 8'h7F : 8'($random(seed));
            slow <= 1'(i / 4);
            issue(BSM_OP_SET_ONE, 4'h0, 16'h0000);
            issue(BSM_OP_TEST, 4'h0, 16'h0000);
            issue(BSM_OP_SET_ZERO, 4'h0, 16'h0000);
            issue(BSM_OP_TEST, 4'h0, 16'h0000);
        end
        give_verdict();
    end

    // about 64 operations of at most 140 cycles each; this is twice that
    initial begin
        repeat (18000) @(posedge i_clk_sys);
        bad_count++;
        give_verdict();
    end
endmodule : tb_bit_serial_io_bus_master
